// ===== hdl/sbr_pkg.sv
// Shared constants and types for the synchronous burst read port.
// Assumes both ends run on one 25 MHz system clock.
package sbr_pkg;
  localparam int unsigned SBR_ADDR_W = 21;
  localparam int unsigned SBR_DATA_W = 16;
  localparam int unsigned SBR_CLK_NS = 40;
  // Longest burst duration, ns
  localparam int unsigned SBR_MAX_BURST_NS = 2500;
  localparam int unsigned SBR_MAX_BURST_CYC = SBR_MAX_BURST_NS / SBR_CLK_NS;
  // Gap from burst end to next start, ns (least, rounded up)
  localparam int unsigned SBR_GAP_NS = 7;
  localparam int unsigned SBR_GAP_CYC = (SBR_GAP_NS + SBR_CLK_NS - 1) / SBR_CLK_NS;
  // Byte enable / output enable lead before last latency edge, cycles
  localparam int unsigned SBR_LEAD_CYC = 1;
  localparam int unsigned SBR_LATENCY = 5;
  localparam int unsigned SBR_BURST_LEN = 4;
  localparam int unsigned SBR_CNT_W = 8;
  localparam logic [SBR_CNT_W-1:0] SBR_CNT_ZERO = 8'h00;
  localparam logic [SBR_CNT_W-1:0] SBR_CNT_ONE = 8'h01;
  // Address bits of the memory array held by the device model
  localparam int unsigned SBR_MEM_AW = 8;
  typedef enum logic [3:0] {
    SBR_ST_IDLE = 4'b0001,
    SBR_ST_LAT = 4'b0010,
    SBR_ST_DATA = 4'b0100,
    SBR_ST_GAP = 4'b1000
  } sbr_state_t;
endpackage

// ===== hdl/sbr_if.sv
// Pin-level link between the memory controller and the burst memory.
// Assumes the bench resolves the wait and data wires from the enables.
`timescale 1ns/10ps
`default_nettype none
interface sbr_if;
  import sbr_pkg::*;
  logic chip_select_n;
  logic address_valid_n;
  logic write_enable_n;
  logic output_enable_n;
  logic upper_byte_enable_n;
  logic lower_byte_enable_n;
  logic [SBR_ADDR_W-1:0] addr;
  logic [SBR_DATA_W-1:0] data_from_mem;
  logic data_from_mem_oe;
  logic [SBR_DATA_W-1:0] data_to_mem;
  logic data_to_mem_oe;
  logic wait_n;
  logic wait_oe;
  modport mem (
    input chip_select_n, address_valid_n, write_enable_n, output_enable_n,
    input upper_byte_enable_n, lower_byte_enable_n, addr, data_to_mem, data_to_mem_oe,
    output data_from_mem, data_from_mem_oe, wait_n, wait_oe
  );
  modport ctl (
    output chip_select_n, address_valid_n, write_enable_n, output_enable_n,
    output upper_byte_enable_n, lower_byte_enable_n, addr, data_to_mem, data_to_mem_oe,
    input data_from_mem, data_from_mem_oe, wait_n, wait_oe
  );
endinterface
`default_nettype wire

// ===== hdl/sbr_mem.sv
// Memory end of the synchronous burst port: burst read and write engine.
// Assumes controller pins arrive registered on the same system clock.
`timescale 1ns/10ps
`default_nettype none
module sbr_mem
  import sbr_pkg::*;
#(
  parameter int unsigned LATENCY = SBR_LATENCY,
  parameter int unsigned BURST_LEN = SBR_BURST_LEN
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Controller link
  sbr_if.mem link,
  // Status
  output logic busy_out,
  output logic write_burst_out
);
  localparam logic [SBR_CNT_W-1:0] LAT_LAST = SBR_CNT_W'(LATENCY - 1);
  localparam logic [SBR_CNT_W-1:0] LEN_LAST = SBR_CNT_W'(BURST_LEN - 1);
  localparam logic [SBR_ADDR_W-1:0] WRAP_MASK = SBR_ADDR_W'(BURST_LEN - 1);

  logic [SBR_DATA_W-1:0] mem_ff [0:(1<<SBR_MEM_AW)-1];
  sbr_state_t state_ff;
  logic [SBR_CNT_W-1:0] cnt_ff;
  logic [SBR_ADDR_W-1:0] addr_ff;
  logic adv_d_ff;
  logic cs_d_ff;
  logic wr_ff;
  logic wait_n_ff;
  logic wait_oe_ff;
  logic [SBR_DATA_W-1:0] dout_ff;
  logic dout_oe_ff;

  logic start;
  logic [SBR_ADDR_W-1:0] nxt_addr;
  logic [SBR_MEM_AW-1:0] beat_idx;
  assign start = !link.chip_select_n && !link.address_valid_n && adv_d_ff;
  assign nxt_addr = (addr_ff & ~WRAP_MASK) | ((addr_ff + SBR_ADDR_W'(1)) & WRAP_MASK);
  assign beat_idx = addr_ff[SBR_MEM_AW-1:0];

  ////////////////////////////////////////////////////////////////////////
  // Edge history of select and valid
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      adv_d_ff <= 1'b1;
      cs_d_ff <= 1'b1;
    end else begin
      // Held-low valid only starts once, at its first edge
      adv_d_ff <= link.address_valid_n | link.chip_select_n;
      cs_d_ff <= link.chip_select_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Burst sequencer
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      state_ff <= SBR_ST_IDLE;
      cnt_ff <= SBR_CNT_ZERO;
      addr_ff <= '0;
      wr_ff <= 1'b0;
    end else if (link.chip_select_n) begin
      state_ff <= SBR_ST_IDLE;
      cnt_ff <= SBR_CNT_ZERO;
    end else if (start) begin
      state_ff <= (LATENCY > 1) ? SBR_ST_LAT : SBR_ST_DATA;
      cnt_ff <= SBR_CNT_ONE;
      addr_ff <= link.addr;
      wr_ff <= !link.write_enable_n;
    end else begin
      unique case (state_ff)
        SBR_ST_IDLE: begin
          cnt_ff <= SBR_CNT_ZERO;
        end
        SBR_ST_LAT: begin
          if (cnt_ff == LAT_LAST) begin
            state_ff <= SBR_ST_DATA;
            cnt_ff <= SBR_CNT_ZERO;
          end else begin
            cnt_ff <= cnt_ff + SBR_CNT_ONE;
          end
        end
        SBR_ST_DATA: begin
          addr_ff <= nxt_addr;
          if (cnt_ff == LEN_LAST) begin
            // Last word stays on the bus until select rises
            state_ff <= SBR_ST_GAP;
          end else begin
            cnt_ff <= cnt_ff + SBR_CNT_ONE;
          end
        end
        SBR_ST_GAP: begin
          cnt_ff <= cnt_ff;
        end
        default: begin
          state_ff <= SBR_ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write beats into the array
  always_ff @(posedge clk_sys_in) begin
    if (state_ff == SBR_ST_DATA && wr_ff && !link.chip_select_n) begin
      // A beat with both byte lanes off is left untouched
      if (!link.upper_byte_enable_n) begin
        mem_ff[beat_idx][15:8] <= link.data_to_mem[15:8];
      end
      if (!link.lower_byte_enable_n) begin
        mem_ff[beat_idx][7:0] <= link.data_to_mem[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wait signalling
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      wait_n_ff <= 1'b0;
      wait_oe_ff <= 1'b0;
    end else if (link.chip_select_n) begin
      wait_n_ff <= 1'b0;
      wait_oe_ff <= 1'b0;
    end else if (start || (cs_d_ff && !link.chip_select_n)) begin
      wait_n_ff <= 1'b0;
      wait_oe_ff <= 1'b1;
    end else if (state_ff == SBR_ST_LAT && cnt_ff == LAT_LAST - SBR_CNT_ONE) begin
      // Ready one edge ahead so data lines up with the final latency edge
      wait_n_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data drive
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      dout_ff <= '0;
      dout_oe_ff <= 1'b0;
    end else begin
      // Drive only when output enable and a byte lane were given in time
      dout_oe_ff <= !link.chip_select_n && !wr_ff && !start && !link.output_enable_n
                    && !(link.upper_byte_enable_n && link.lower_byte_enable_n)
                    && (state_ff == SBR_ST_DATA || state_ff == SBR_ST_GAP);
      if (state_ff == SBR_ST_DATA) begin
        dout_ff <= mem_ff[beat_idx];
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      busy_out <= 1'b0;
      write_burst_out <= 1'b0;
    end else begin
      busy_out <= (state_ff == SBR_ST_LAT) || (state_ff == SBR_ST_DATA);
      write_burst_out <= wr_ff;
    end
  end

  assign link.wait_n = wait_n_ff;
  assign link.wait_oe = wait_oe_ff;
  assign link.data_from_mem = dout_ff;
  assign link.data_from_mem_oe = dout_oe_ff;
endmodule
`default_nettype wire

// ===== hdl/sbr_ctl.sv
// Controller end: issues burst reads and writes on request.
// Assumes one request at a time; held off by busy until the gap ends.
`timescale 1ns/10ps
`default_nettype none
module sbr_ctl
  import sbr_pkg::*;
#(
  parameter int unsigned LATENCY = SBR_LATENCY,
  parameter int unsigned BURST_LEN = SBR_BURST_LEN
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // User request
  input wire logic req_in,
  input wire logic req_write_in,
  input wire logic [SBR_ADDR_W-1:0] req_addr_in,
  input wire logic [SBR_DATA_W-1:0] wdata_in,
  input wire logic [1:0] wmask_n_in,
  output logic busy_out,
  // Read answer
  output logic rvalid_out,
  output logic [SBR_DATA_W-1:0] rdata_out,
  // Memory link
  sbr_if.ctl link
);
  localparam logic [SBR_CNT_W-1:0] LAT_LAST = SBR_CNT_W'(LATENCY - 1);
  localparam logic [SBR_CNT_W-1:0] LEN_LAST = SBR_CNT_W'(BURST_LEN - 1);
  localparam logic [SBR_CNT_W-1:0] GAP_CYC = SBR_CNT_W'(SBR_GAP_CYC);
  localparam logic [SBR_CNT_W-1:0] MAX_CYC = SBR_CNT_W'(SBR_MAX_BURST_CYC);

  sbr_state_t state_ff;
  logic [SBR_CNT_W-1:0] cnt_ff;
  logic [SBR_CNT_W-1:0] dur_ff;
  logic wr_ff;
  logic cs_n_ff, adv_n_ff, we_n_ff, oe_n_ff, ub_n_ff, lb_n_ff, dout_oe_ff;
  logic [SBR_ADDR_W-1:0] addr_ff;
  logic [SBR_DATA_W-1:0] dout_ff;
  logic [SBR_DATA_W-1:0] din_s1_ff, din_s2_ff;
  logic rv_s1_ff, rv_s2_ff;

  ////////////////////////////////////////////////////////////////////////
  // Burst sequencer and pins
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      state_ff <= SBR_ST_IDLE;
      cnt_ff <= SBR_CNT_ZERO;
      dur_ff <= SBR_CNT_ZERO;
      wr_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      adv_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      ub_n_ff <= 1'b1;
      lb_n_ff <= 1'b1;
      addr_ff <= '0;
      dout_ff <= '0;
      dout_oe_ff <= 1'b0;
    end else begin
      adv_n_ff <= 1'b1;
      dur_ff <= (state_ff == SBR_ST_IDLE) ? SBR_CNT_ZERO : dur_ff + SBR_CNT_ONE;
      unique case (state_ff)
        SBR_ST_IDLE: begin
          if (req_in) begin
            state_ff <= (LATENCY > 1) ? SBR_ST_LAT : SBR_ST_DATA;
            // Pins lead the memory's start edge by one cycle, so count from zero
            cnt_ff <= SBR_CNT_ZERO;
            wr_ff <= req_write_in;
            cs_n_ff <= 1'b0;
            adv_n_ff <= 1'b0;
            addr_ff <= req_addr_in;
            we_n_ff <= !req_write_in;
            // Read enables go out at once, well ahead of the last latency edge; write byte lanes wait for it
            oe_n_ff <= req_write_in;
            ub_n_ff <= req_write_in;
            lb_n_ff <= req_write_in;
          end
        end
        SBR_ST_LAT: begin
          we_n_ff <= 1'b1;
          if (cnt_ff == LAT_LAST) begin
            state_ff <= SBR_ST_DATA;
            cnt_ff <= SBR_CNT_ZERO;
            if (wr_ff) begin
              {ub_n_ff, lb_n_ff} <= wmask_n_in;
              dout_ff <= wdata_in;
              dout_oe_ff <= 1'b1;
            end
          end else begin
            cnt_ff <= cnt_ff + SBR_CNT_ONE;
          end
        end
        SBR_ST_DATA: begin
          if (wr_ff) begin
            {ub_n_ff, lb_n_ff} <= wmask_n_in;
            dout_ff <= wdata_in;
          end
          // Stop early rather than overrun the burst duration limit
          if (cnt_ff == LEN_LAST || dur_ff >= MAX_CYC - SBR_CNT_ONE) begin
            state_ff <= SBR_ST_GAP;
            cnt_ff <= SBR_CNT_ZERO;
            cs_n_ff <= 1'b1;
            oe_n_ff <= 1'b1;
            ub_n_ff <= 1'b1;
            lb_n_ff <= 1'b1;
            dout_oe_ff <= 1'b0;
          end else begin
            cnt_ff <= cnt_ff + SBR_CNT_ONE;
          end
        end
        SBR_ST_GAP: begin
          if (cnt_ff >= GAP_CYC) begin
            state_ff <= SBR_ST_IDLE;
          end else begin
            cnt_ff <= cnt_ff + SBR_CNT_ONE;
          end
        end
        default: begin
          state_ff <= SBR_ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data capture through two stages, data from a pin
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      din_s1_ff <= '0;
      din_s2_ff <= '0;
      rv_s1_ff <= 1'b0;
      rv_s2_ff <= 1'b0;
      rvalid_out <= 1'b0;
      rdata_out <= '0;
      busy_out <= 1'b1;
    end else begin
      din_s1_ff <= link.data_from_mem;
      din_s2_ff <= din_s1_ff;
      rv_s1_ff <= link.data_from_mem_oe && link.wait_oe && link.wait_n;
      rv_s2_ff <= rv_s1_ff;
      rvalid_out <= rv_s2_ff && !wr_ff;
      rdata_out <= din_s2_ff;
      busy_out <= (state_ff != SBR_ST_IDLE) || req_in;
    end
  end

  assign link.chip_select_n = cs_n_ff;
  assign link.address_valid_n = adv_n_ff;
  assign link.write_enable_n = we_n_ff;
  assign link.output_enable_n = oe_n_ff;
  assign link.upper_byte_enable_n = ub_n_ff;
  assign link.lower_byte_enable_n = lb_n_ff;
  assign link.addr = addr_ff;
  assign link.data_to_mem = dout_ff;
  assign link.data_to_mem_oe = dout_oe_ff;
endmodule
`default_nettype wire

// ===== sim/sbr_link_asserts.sv
// Checker on the link between controller and memory ends.
// Assumes the bench instantiates it beside the joining interface.
`timescale 1ns/10ps
`default_nettype none
module sbr_link_asserts
  import sbr_pkg::*;
#(
  parameter int unsigned LATENCY = SBR_LATENCY
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Link signals
  input wire logic chip_select_n,
  input wire logic address_valid_n,
  input wire logic write_enable_n,
  input wire logic output_enable_n,
  input wire logic upper_byte_enable_n,
  input wire logic lower_byte_enable_n,
  input wire logic data_from_mem_oe,
  input wire logic wait_n,
  input wire logic wait_oe
);
  localparam int LAT = LATENCY;
  localparam int LAT_P1 = LATENCY + 1;
  localparam int LAT_M1 = LATENCY - 1;
  localparam int MAX_CYC = SBR_MAX_BURST_CYC;
  logic [SBR_CNT_W-1:0] low_cnt_ff;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  ////////////////////////////////////////////////////////////////////////////////
  // Select-low cycles; a counter, as the limit is too long to unroll
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in || chip_select_n) begin
      low_cnt_ff <= SBR_CNT_ZERO;
    end else begin
      low_cnt_ff <= low_cnt_ff + SBR_CNT_ONE;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_start;
    !chip_select_n && !address_valid_n && ($past(address_valid_n) || $past(chip_select_n));
  endsequence
  sequence s_read;
    s_start ##0 write_enable_n;
  endsequence
  sequence s_write;
    s_start ##0 !write_enable_n;
  endsequence
  a_wait_not_ready: assert property (s_start |=> wait_oe && !wait_n)
    else $error("wait not driven low after burst start");
  a_wait_ready_edge: assert property (s_start |-> ##LAT_M1 $rose(wait_n))
    else $error("wait did not turn ready one cycle before latency end");
  a_wait_release: assert property ($rose(chip_select_n) |=> !wait_oe)
    else $error("wait still driven after deselect");
  a_gap_idle: assert property ($rose(chip_select_n) |-> (chip_select_n && address_valid_n)[*2])
    else $error("new burst started inside the gap");
  a_burst_limit: assert property (low_cnt_ff < MAX_CYC)
    else $error("burst held longer than the limit");
  a_byte_lead: assert property (s_read |-> ##LAT_M1 (!upper_byte_enable_n && !lower_byte_enable_n))
    else $error("byte enables late for read");
  a_oe_lead: assert property (s_read |-> ##LAT_M1 !output_enable_n)
    else $error("output enable late for read");
  a_read_words: assert property (s_read |-> ##LAT_P1 data_from_mem_oe[*4])
    else $error("read words missing after latency");
  a_write_quiet: assert property (s_write |-> ##LAT !data_from_mem_oe)
    else $error("memory drove data during a write burst");
endmodule
`default_nettype wire

// ===== sim/test_sync_burst_read_port.sv
// Bench: controller and memory ends joined, driven from the user side.
// Assumes default latency and burst length of the package.
`timescale 1ns/10ps
`default_nettype none
module test_sync_burst_read_port;
  import sbr_pkg::*;
  localparam time SKEW = 2ns;
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic req_in = 1'b0;
  logic req_write_in = 1'b0;
  logic [SBR_ADDR_W-1:0] req_addr_in = 21'h000000;
  logic [SBR_DATA_W-1:0] wdata_in = 16'h0000;
  logic [1:0] wmask_n_in = 2'h0;
  logic ctl_busy, rvalid, mem_busy, mem_write;
  logic [SBR_DATA_W-1:0] rdata;
  int failures = 0;
  int checked = 0;
  sbr_if sbr_if_i ();
  sbr_ctl sbr_ctl_i (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .req_in(req_in),
    .req_write_in(req_write_in), .req_addr_in(req_addr_in), .wdata_in(wdata_in),
    .wmask_n_in(wmask_n_in), .busy_out(ctl_busy), .rvalid_out(rvalid), .rdata_out(rdata),
    .link(sbr_if_i));
  sbr_mem sbr_mem_i (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .link(sbr_if_i),
    .busy_out(mem_busy), .write_burst_out(mem_write));
  sbr_link_asserts sbr_link_asserts_i (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .chip_select_n(sbr_if_i.chip_select_n), .address_valid_n(sbr_if_i.address_valid_n),
    .write_enable_n(sbr_if_i.write_enable_n), .output_enable_n(sbr_if_i.output_enable_n),
    .upper_byte_enable_n(sbr_if_i.upper_byte_enable_n),
    .lower_byte_enable_n(sbr_if_i.lower_byte_enable_n),
    .data_from_mem_oe(sbr_if_i.data_from_mem_oe), .wait_n(sbr_if_i.wait_n),
    .wait_oe(sbr_if_i.wait_oe));
  always #20ns clk_sys_in = ~clk_sys_in;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [SBR_DATA_W-1:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic tick();
    @(posedge clk_sys_in);
    #SKEW;
  endtask
  // Requests only while idle; a busy controller would drop them
  task automatic issue(input logic wr, input logic [SBR_ADDR_W-1:0] a,
      input logic [SBR_DATA_W-1:0] d, input logic [1:0] m);
    int n;
    n = 0;
    while (ctl_busy !== 1'b0 && n < 200) begin
      tick();
      n++;
    end
    req_write_in = wr;
    req_addr_in = a;
    wdata_in = d;
    wmask_n_in = m;
    req_in = 1'b1;
    tick();
    req_in = 1'b0;
  endtask
  task automatic write_burst(input logic [SBR_ADDR_W-1:0] a,
      input logic [SBR_DATA_W-1:0] d, input logic [1:0] m);
    issue(1'b1, a, d, m);
    // Start edge, then one more for the registered flag
    tick();
    tick();
    check("write flag", 16'(mem_write), 16'h0001);
  endtask
  task automatic read_burst(input logic [SBR_ADDR_W-1:0] a, input logic [SBR_DATA_W-1:0] exp);
    int got;
    int n;
    got = 0;
    n = 0;
    issue(1'b0, a, wdata_in, wmask_n_in);
    tick();
    tick();
    n = 2;
    check("read flag", 16'(mem_write), 16'h0000);
    while (got < SBR_BURST_LEN && n < 60) begin
      if (rvalid === 1'b1) begin
        check("read word", rdata, exp);
        got++;
      end
      tick();
      n++;
    end
    check("word count", 16'(got), 16'(SBR_BURST_LEN));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_full_word();
    write_burst(21'h000010, 16'ha55a, 2'h0);
    read_burst(21'h000010, 16'ha55a);
  endtask
  task automatic t_byte_masks();
    write_burst(21'h000010, 16'h3cc3, 2'h2);
    read_burst(21'h000010, 16'ha5c3);
    write_burst(21'h000010, 16'hffff, 2'h3);
    read_burst(21'h000010, 16'ha5c3);
  endtask
  // Second read issued as soon as the first read has counted its last word
  task automatic t_back_to_back();
    write_burst(21'h000020, 16'h1234, 2'h0);
    read_burst(21'h000020, 16'h1234);
    read_burst(21'h000010, 16'ha5c3);
  endtask
  task automatic t_reset_mid();
    issue(1'b0, 21'h000020, wdata_in, wmask_n_in);
    tick();
    nrst_in = 1'b0;
    tick();
    nrst_in = 1'b1;
    tick();
    check("select after reset", 16'(sbr_if_i.chip_select_n), 16'h0001);
    check("wait after reset", 16'(sbr_if_i.wait_oe), 16'h0000);
    check("mem busy after reset", 16'(mem_busy), 16'h0000);
    read_burst(21'h000020, 16'h1234);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_sys_in);
    #SKEW;
    nrst_in = 1'b1;
    tick();
    t_full_word();
    t_byte_masks();
    t_back_to_back();
    t_reset_mid();
    report_and_stop();
  end
  // Tests need well under a thousand cycles
  initial begin
    #(40ns * 5000);
    failures++;
    report_and_stop();
  end
endmodule
`default_nettype wire
